/* include/rsv_pkg.sv */
// Function
// - pin-enable bit 0 set to 1 makes the shared pin an active-low reset input
// - during power-on the shared pin always acts as reset input
// - only power-on overrides the pin function; other resets do not
// - six reset sources: pin, power-on, brownout, watchdog, software, break
// - flags stay set until software writes 0 or a power-on or watchdog reset reloads them; writing 1 changes nothing
// - power-on reset sets power-on and brownout flags, clears the rest
// - watchdog reset sets flags like a power-on reset, but keeps the brownout interrupt flag and sets bit 2 when ctrl bit 3 is set
// - other resets set their own flag and keep uncleared earlier flags
// - pin flag set by pin reset or pin still low after power-on
// - software flag marks software reset; cleared by write 0, power-on or watchdog reset
// - break with break-reset enable resets the system and sets bit 3
// - brownout flag set on brownout reset, power-on flag on power-on
// - brownout interrupt flag set on event, stays until software writes 0 or a power-on reset clears it
// - boot address is boot vector as high byte, low byte zero
// - boot address after break reset, boot status bit 0, or forced isp
// - brownout irq enable makes brownout raise an interrupt, not reset
`default_nettype none
package rsv_pkg;
   localparam logic [7:0]  ADDR_CAUSE   = 8'hDF;
   // registers of our own, byte addresses on the bus
   localparam logic [7:0]  ADDR_CTRL    = 8'hE0;
   localparam logic [7:0]  ADDR_VECTOR  = 8'hE4;
   localparam int          BIT_PIN      = 0;
   localparam int          BIT_SOFT     = 1;
   localparam int          BIT_WDOG     = 2;
   localparam int          BIT_BREAK    = 3;
   localparam int          BIT_POWER    = 4;
   localparam int          BIT_BROWN    = 5;
   localparam int          BIT_BOIRQ    = 6;
   localparam logic [7:0]  CAUSE_POR    = 8'h30;
   localparam logic [7:0]  CAUSE_MASK   = 8'h7F;
   // ctrl: 0 reset_pin_enable, 1 break_reset_enable, 2 brownout_irq_enable,
   //       3 watchdog flag valid (config byte bit 7), 4 software reset request
   localparam int          CTL_RPE      = 0;
   localparam int          CTL_BRE      = 1;
   localparam int          CTL_BOI      = 2;
   localparam int          CTL_WDV      = 3;
   localparam int          CTL_SWR      = 4;
   localparam logic [7:0]  CTRL_RESET   = 8'h08;
   localparam logic [7:0]  VECTOR_RESET = 8'h00;
   localparam logic [15:0] FETCH_ZERO   = 16'h0000;
   localparam logic [7:0]  BOOT_LOW     = 8'h00;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } rsv_wb_req_t;

   typedef struct packed {
      logic        power_on;
      logic        pin_low;
      logic        brownout;
      logic        watchdog;
      logic        uart_break;
      logic        boot_stat0;
      logic        isp_forced;
   } rsv_src_t;

   typedef struct packed {
      logic [7:0]  cause;
      logic [7:0]  ctrl;
      logic [7:0]  vector;
      logic        por_seen;
      logic        ack;
      logic [31:0] rdat;
      logic        sys_rst;
      logic        boot_sel;
      logic [15:0] fetch;
      logic        irq;
      logic        pin_in;
   } rsv_state_t;
endpackage : rsv_pkg
`default_nettype wire

/* core/rsv_reset_logic.sv */
// Added by the designer: the Wishbone register port.
`default_nettype none
module rsv_reset_logic (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire rsv_pkg::rsv_wb_req_t wb_i,
   output logic                    wb_ack_o,
   output logic [31:0]             wb_dat_o,
   input  wire rsv_pkg::rsv_src_t  src_i,
   output logic                    sys_rst_o,
   output logic [15:0]             fetch_addr_o,
   output logic                    brownout_irq_o,
   output logic                    pin_input_o
);
   rsv_pkg::rsv_state_t s_q;
   rsv_pkg::rsv_state_t s_d;
   logic                pin_rst;
   logic                soft_rst;
   logic                brk_rst;
   logic                brn_rst;
   logic                wd_rst;
   logic                any_rst;
   logic                wr;
   logic [7:0]          wbyte;

   always_comb begin
      // power-on forces reset function; otherwise the config bit decides
      pin_rst  = src_i.pin_low &&
                 (src_i.power_on || s_q.ctrl[rsv_pkg::CTL_RPE]);
      soft_rst = s_q.ctrl[rsv_pkg::CTL_SWR];
      brk_rst  = src_i.uart_break && s_q.ctrl[rsv_pkg::CTL_BRE];
      // with interrupt enabled a brownout only flags, never resets
      brn_rst  = src_i.brownout && !s_q.ctrl[rsv_pkg::CTL_BOI];
      wd_rst   = src_i.watchdog;
      any_rst  = src_i.power_on || pin_rst || soft_rst || brk_rst ||
                 brn_rst || wd_rst;
      wr       = wb_i.cyc && wb_i.stb && wb_i.we && !s_q.ack && wb_i.sel[0];
      wbyte    = wb_i.dat[7:0];
      s_d      = s_q;
      s_d.ack  = wb_i.cyc && wb_i.stb && !s_q.ack;
      s_d.rdat = 32'h0000_0000;
      if (wb_i.cyc && wb_i.stb && !s_q.ack && !wb_i.we) begin
         unique case (wb_i.adr)
            rsv_pkg::ADDR_CAUSE:  s_d.rdat[7:0] = s_q.cause;
            rsv_pkg::ADDR_CTRL:   s_d.rdat[7:0] = s_q.ctrl;
            rsv_pkg::ADDR_VECTOR: s_d.rdat[7:0] = s_q.vector;
            default:              s_d.rdat      = 32'h0000_0000;
         endcase
      end
      // software clears by writing 0; writing 1 keeps the flag
      if (wr && wb_i.adr == rsv_pkg::ADDR_CAUSE) begin
         s_d.cause = s_q.cause & (wbyte | ~rsv_pkg::CAUSE_MASK) &
                     rsv_pkg::CAUSE_MASK;
      end
      if (wr && wb_i.adr == rsv_pkg::ADDR_CTRL) begin
         s_d.ctrl = wbyte;
      end
      if (wr && wb_i.adr == rsv_pkg::ADDR_VECTOR) begin
         s_d.vector = wbyte;
      end
      // hardware sets after the clear so a same-cycle event is not lost
      if (src_i.brownout && s_q.ctrl[rsv_pkg::CTL_BOI]) begin
         s_d.cause[rsv_pkg::BIT_BOIRQ] = 1'b1;
      end
      if (src_i.power_on || wd_rst) begin
         s_d.cause = rsv_pkg::CAUSE_POR;
         s_d.cause[rsv_pkg::BIT_BOIRQ] = s_q.cause[rsv_pkg::BIT_BOIRQ] &&
                                         !src_i.power_on;
         if (wd_rst && !src_i.power_on && s_q.ctrl[rsv_pkg::CTL_WDV]) begin
            s_d.cause[rsv_pkg::BIT_WDOG] = 1'b1;
         end
      end else begin
         if (pin_rst) begin
            s_d.cause[rsv_pkg::BIT_PIN] = 1'b1;
         end
         if (soft_rst) begin
            s_d.cause[rsv_pkg::BIT_SOFT] = 1'b1;
         end
         if (brk_rst) begin
            s_d.cause[rsv_pkg::BIT_BREAK] = 1'b1;
         end
         if (brn_rst) begin
            s_d.cause[rsv_pkg::BIT_BROWN] = 1'b1;
         end
      end
      // pin held low at the end of power-on counts as pin reset
      s_d.por_seen = src_i.power_on;
      if (s_q.por_seen && !src_i.power_on && src_i.pin_low) begin
         s_d.cause[rsv_pkg::BIT_PIN] = 1'b1;
      end
      if (src_i.power_on) begin
         s_d.ctrl   = rsv_pkg::CTRL_RESET;
         s_d.vector = rsv_pkg::VECTOR_RESET;
      end else if (any_rst) begin
         // the pin function survives non-power-on resets
         s_d.ctrl[rsv_pkg::CTL_SWR] = 1'b0;
      end
      s_d.sys_rst = any_rst;
      // fetch address is latched while reset is active
      if (any_rst) begin
         s_d.boot_sel = brk_rst || src_i.boot_stat0 || src_i.isp_forced;
         s_d.fetch    = s_d.boot_sel ? {s_q.vector, rsv_pkg::BOOT_LOW}
                                     : rsv_pkg::FETCH_ZERO;
      end
      s_d.irq    = s_d.cause[rsv_pkg::BIT_BOIRQ];
      // only a true input when the pin is not acting as reset
      s_d.pin_in = !src_i.pin_low &&
                   !(src_i.power_on || s_d.ctrl[rsv_pkg::CTL_RPE]);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '{cause:    rsv_pkg::CAUSE_POR,
                  ctrl:     rsv_pkg::CTRL_RESET,
                  vector:   rsv_pkg::VECTOR_RESET,
                  por_seen: 1'b0,
                  ack:      1'b0,
                  rdat:     32'h0000_0000,
                  sys_rst:  1'b0,
                  boot_sel: 1'b0,
                  fetch:    rsv_pkg::FETCH_ZERO,
                  irq:      1'b0,
                  pin_in:   1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_ack_o       = s_q.ack;
   assign wb_dat_o       = s_q.rdat;
   assign sys_rst_o      = s_q.sys_rst;
   assign fetch_addr_o   = s_q.fetch;
   assign brownout_irq_o = s_q.irq;
   assign pin_input_o    = s_q.pin_in;
endmodule : rsv_reset_logic
`default_nettype wire

/* bench/rsv_src_model.sv */
`default_nettype none
module rsv_src_model (
   input  wire logic         clk_i,
   input  wire logic [6:0]   req_i,
   output var rsv_pkg::rsv_src_t src_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial src_o = '0;
   always @(posedge clk_i) begin
      src_o <= req_i;
      // pin let go while power comes up, else power-on never ends
      if (req_i[6]) src_o.pin_low <= 1'b0;
   end
endmodule : rsv_src_model
`default_nettype wire

/* bench/rsv_reset_logic_chk.sv */
`default_nettype none
module rsv_chk (
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire rsv_pkg::rsv_wb_req_t wb_i,
   input wire logic                 wb_ack_o,
   input wire logic [31:0]          wb_dat_o,
   input wire rsv_pkg::rsv_src_t    src_i,
   input wire logic                 sys_rst_o,
   input wire logic [15:0]          fetch_addr_o,
   input wire logic                 brownout_irq_o,
   input wire logic                 pin_input_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_taken: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o
      |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
   // registers are one byte wide; the vector may use bit 7
   a_dat_upper: assert property (
      wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits");
   a_por_reset: assert property (
      src_i.power_on |=> sys_rst_o) else $error("no por reset");
   a_wdog_reset: assert property (
      src_i.watchdog |=> sys_rst_o) else $error("no wdog reset");
   a_pin_low_in: assert property (
      src_i.pin_low |=> !pin_input_o) else $error("pin level");
   a_irq_cause: assert property (
      $rose(brownout_irq_o) |-> $past(src_i.brownout)
      || $past(src_i.brownout, 2)) else $error("irq cause");
   a_irq_sticky: assert property (
      brownout_irq_o && !wb_i.cyc && !src_i.power_on
      && !$past(src_i.power_on) |=> brownout_irq_o) else $error("irq lost");
   a_fetch_low: assert property (
      fetch_addr_o[7:0] == 8'h00) else $error("fetch low");
   c_ack: cover property (wb_ack_o);
   c_irq: cover property ($rose(brownout_irq_o));
   c_boot: cover property (fetch_addr_o != 16'h0);
endmodule : rsv_chk
bind rsv_reset_logic rsv_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_i(wb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .src_i(src_i),
   .sys_rst_o(sys_rst_o), .fetch_addr_o(fetch_addr_o),
   .brownout_irq_o(brownout_irq_o), .pin_input_o(pin_input_o));
`default_nettype wire

/* bench/rsv_reset_logic_bench.sv */
`default_nettype none
module rsv_reset_logic_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk_i, rst_i, ack, sr, irq, pin, seen;
   logic [31:0]          dat;
   logic [15:0]          fa;
   logic [7:0]           q, ex, v, m, st;
   logic [6:0]           req;
   logic [6:0]           rq [8];
   int                   bs [8], error_cnt, compares, k;
   rsv_pkg::rsv_wb_req_t wb;
   rsv_pkg::rsv_src_t    src;
   rsv_src_model pm (.clk_i(clk_i), .req_i(req), .src_o(src));
   rsv_reset_logic uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb),
      .wb_ack_o(ack), .wb_dat_o(dat), .src_i(src), .sys_rst_o(sr),
      .fetch_addr_o(fa), .brownout_irq_o(irq), .pin_input_o(pin));
   function automatic logic [7:0] rnd();
      st = st ^ (st << 3);
      st = st ^ (st >> 5);
      return st;
   endfunction : rnd
   function automatic logic [7:0] nxt(input logic [7:0] f, input int b);
      if (b == rsv_pkg::BIT_POWER) return rsv_pkg::CAUSE_POR;
      if (b == rsv_pkg::BIT_WDOG) return (f & 8'h40) | 8'h34;
      return f | (8'h01 << b);
   endfunction : nxt
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %0t got %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      wb <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
      for (n = 0; n < 9 && ack !== 1'b1; n++) @(posedge clk_i);
      chk(ack, 1'b1);
      q = dat[7:0];
      wb <= '0;
      @(posedge clk_i);
   endtask : bus
   task automatic pulse(input logic [6:0] r);
      req <= r;
      @(posedge clk_i);
      req <= '0;
      seen = 1'b0;
      // look mid-cycle so the one-cycle reset pulse is seen settled
      repeat (5) begin
         @(negedge clk_i);
         seen = seen | sr;
      end
      @(posedge clk_i);
   endtask : pulse
   task automatic print_verdict();
      if (error_cnt == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      error_cnt++;
      print_verdict();
   end
   initial begin
      rq = '{7'h20, 7'h00, 7'h04, 7'h11, 7'h12, 7'h10, 7'h08, 7'h40};
      bs = '{0, 1, 3, 5, 5, 5, 2, 4};
      rst_i = 1'b1;
      wb = '0;
      req = 7'h00;
      st = 8'h5C;
      error_cnt = 0;
      compares = 0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, rsv_pkg::ADDR_CAUSE, 8'h00);
      chk(q, rsv_pkg::CAUSE_POR);
      bus(0, 8'h10, 8'h00);
      chk(q, 8'h00);
      v = rnd();
      bus(1, rsv_pkg::ADDR_VECTOR, v);
      bus(1, rsv_pkg::ADDR_CTRL, 8'h0B);
      ex = rsv_pkg::CAUSE_POR;
      for (k = 0; k < 8; k++) begin
         if (rq[k] == 7'h00) bus(1, rsv_pkg::ADDR_CTRL, 8'h1B);
         pulse(rq[k]);
         ex = nxt(ex, bs[k]);
         if (rq[k] != 7'h00) chk(seen, 1'b1);
         chk(fa, (bs[k] == 3 || rq[k][1:0] != 0) ? {v, 8'h00} : 16'h0);
         bus(0, rsv_pkg::ADDR_CAUSE, 8'h00);
         chk(q, ex);
         m = rnd();
         bus(1, rsv_pkg::ADDR_CAUSE, m);
         ex = ex & m & 8'h7F;
         bus(0, rsv_pkg::ADDR_CAUSE, 8'h00);
         chk(q, ex);
      end
      bus(1, rsv_pkg::ADDR_CTRL, 8'h04);
      pulse(7'h10);
      chk({seen, irq}, 2'b01);
      bus(1, rsv_pkg::ADDR_CAUSE, 8'hBF);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0);
      pulse(7'h20);
      chk({seen, pin}, 2'b01);
      pulse(7'h08);
      bus(0, rsv_pkg::ADDR_CAUSE, 8'h00);
      chk(q, 8'h30);
      print_verdict();
   end
endmodule : rsv_reset_logic_bench
`default_nettype wire
